// ==== test/pberr_sec_agent.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// secondary bus agent, wires with pull-up
// ----------------------------------------
module pberr_sec_agent (
   input wire logic agent_perr,
   input wire logic agent_serr,
   input wire logic perr_out,
   input wire logic perr_oe,
   input wire logic serr_out,
   input wire logic serr_oe,
   output logic perr_wire_n,
   output logic serr_wire_n
);
   // agent reports its own parity errors
   assign perr_wire_n = !(agent_perr || (perr_oe && !perr_out));
   assign serr_wire_n = !(agent_serr || (serr_oe && !serr_out));
endmodule : pberr_sec_agent

// ==== test/pberr_top_assertions.sv ====
`timescale 1ns/1ps
module pberr_chk #(
   parameter int RETRY_LIMIT = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic txn_valid,
   input wire logic [2:0] txn_kind,
   input wire logic txn_sec_data_perr,
   input wire logic txn_multi_phase,
   input wire logic secondary_perr_n_out,
   input wire logic secondary_perr_n_oe,
   input wire logic pw_target_abort,
   input wire logic pw_init_sec,
   input wire logic cpl_timeout,
   input wire logic cpl_init_sec,
   input wire logic secondary_serr_n_in,
   input wire logic secondary_serr_n_out,
   input wire logic primary_serr_n_out,
   input wire logic primary_serr_n_oe,
   input wire logic fwd_bad_parity,
   input wire logic drop_write,
   input wire logic ret_trdy,
   input wire logic ret_stop,
   input wire logic cpl_discard
);
   logic [5:0] ctrl_q;
   logic [15:0] dis_q;
   wire logic wr_acc = avs_write && !avs_waitrequest;
   wire logic err_txn = txn_valid && txn_sec_data_perr;
   wire logic k_perr = txn_kind == 3'h1 || txn_kind == 3'h3 || txn_kind == 3'h4
      || txn_kind == 3'h6;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_q <= 6'h00;
         dis_q <= 16'h0000;
      end else if (wr_acc && avs_address == 4'h0) begin
         ctrl_q <= avs_writedata[5:0];
      end else if (wr_acc && avs_address == 4'h4) begin
         dis_q <= avs_writedata[15:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_perr_wave;
      (secondary_perr_n_oe && !secondary_perr_n_out)
      ##1 (secondary_perr_n_oe && secondary_perr_n_out) ##1 !secondary_perr_n_oe;
   endsequence
   AST_UPPW_FWD: assert property (err_txn && txn_kind == 3'h1 |=> fwd_bad_parity)
      else $error("bad parity not forwarded");
   AST_PERR_WAVE: assert property (err_txn && ctrl_q[1] && k_perr |=> s_perr_wave)
      else $error("secondary perr waveform wrong");
   AST_UPDW_DROP: assert property (err_txn && ctrl_q[1] && txn_kind == 3'h3
      |=> drop_write && ret_trdy && ret_stop == $past(txn_multi_phase))
      else $error("delayed write not dropped");
   AST_PSERR_EN: assert property (primary_serr_n_oe && !primary_serr_n_out |-> $past(ctrl_q[2]))
      else $error("primary serr without enable");
   AST_TOUT: assert property (cpl_timeout |=> cpl_discard)
      else $error("completion not discarded");
   AST_TOUT_SIDE: assert property (cpl_timeout && !cpl_init_sec && ctrl_q[2] && !dis_q[7]
      |=> primary_serr_n_oe && !primary_serr_n_out)
      else $error("timeout serr missing");
   AST_TABORT_SEC: assert property (pw_target_abort && pw_init_sec && ctrl_q[3] && !dis_q[10]
      |=> !secondary_serr_n_out)
      else $error("target abort serr missing");
   AST_FWD: assert property (!secondary_serr_n_in && ctrl_q[4] && ctrl_q[2] |=> !primary_serr_n_out)
      else $error("serr not forwarded");
endmodule : pberr_chk
bind pberr_top pberr_chk #(.RETRY_LIMIT(RETRY_LIMIT)) u_chk (.clk(clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest), .txn_valid(txn_valid), .txn_kind(txn_kind),
   .txn_sec_data_perr(txn_sec_data_perr), .txn_multi_phase(txn_multi_phase),
   .secondary_perr_n_out(secondary_perr_n_out), .secondary_perr_n_oe(secondary_perr_n_oe),
   .pw_target_abort(pw_target_abort), .pw_init_sec(pw_init_sec),
   .cpl_timeout(cpl_timeout), .cpl_init_sec(cpl_init_sec),
   .secondary_serr_n_in(secondary_serr_n_in), .secondary_serr_n_out(secondary_serr_n_out),
   .primary_serr_n_out(primary_serr_n_out), .primary_serr_n_oe(primary_serr_n_oe),
   .fwd_bad_parity(fwd_bad_parity), .drop_write(drop_write), .ret_trdy(ret_trdy),
   .ret_stop(ret_stop), .cpl_discard(cpl_discard));

// ==== test/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, gt) n_checks++; if ((gt) !== (ex)) begin errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end
module tb;
   localparam int RL_SIM = 4;
   logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, txn_valid = 0, sdp = 0, mph = 0;
   logic trdy = 0, ap = 0, as = 0, paddr = 0, saddr = 0, tab = 0, mab = 0, isec = 0, tout = 0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [2:0] kind = 3'h0, rpul = 3'h0, rdone = 3'h0, rsec = 3'h0, rdisc;
   logic avs_waitrequest, sp_out, sp_oe, pp_out, pp_oe, ss_out, ss_oe, ps_out, ps_oe;
   logic sp_w, ss_w, fwd, drop, rtrdy, rstop, cdisc;
   logic [27:0] tbl [12];
   int errors = 0, n_checks = 0, cyc = 0, ndisc = 0;
   always #5 clk = ~clk;
   pberr_top #(.RETRY_LIMIT(RL_SIM)) DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .txn_valid(txn_valid), .txn_kind(kind), .txn_sec_data_perr(sdp), .txn_pri_perr_seen(1'b0),
      .txn_multi_phase(mph), .pri_trdy_return(trdy), .secondary_perr_n_in(sp_w),
      .secondary_perr_n_out(sp_out), .secondary_perr_n_oe(sp_oe), .primary_perr_n_out(pp_out),
      .primary_perr_n_oe(pp_oe), .pri_addr_perr(paddr), .sec_addr_perr(saddr),
      .pw_target_abort(tab), .pw_master_abort(mab), .pw_init_sec(isec), .retry_pulse(rpul),
      .retry_done(rdone), .retry_init_sec(rsec), .cpl_timeout(tout), .cpl_init_sec(isec),
      .secondary_serr_n_in(ss_w), .secondary_serr_n_out(ss_out), .secondary_serr_n_oe(ss_oe),
      .primary_serr_n_out(ps_out), .primary_serr_n_oe(ps_oe), .fwd_bad_parity(fwd),
      .drop_write(drop), .ret_trdy(rtrdy), .ret_stop(rstop), .retry_discard(rdisc),
      .cpl_discard(cdisc));
   pberr_sec_agent u_agent (.agent_perr(ap), .agent_serr(as), .perr_out(sp_out),
      .perr_oe(sp_oe), .serr_out(ss_out), .serr_oe(ss_oe), .perr_wire_n(sp_w),
      .serr_wire_n(ss_w));
   task automatic print_verdict();
      if (errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic st(input logic [31:0] ex);
      bus(1'b0, 4'h8, 32'h0);
      `CHK("stat", ex, q)
      bus(1'b1, 4'h8, 32'h0000_000F);
   endtask : st
   task automatic ev(input logic [2:0] k, input logic s, input logic m, input logic p);
      repeat (3) @(posedge clk);
      txn_valid <= 1'b1;
      kind <= k;
      sdp <= s;
      mph <= m;
      ap <= p;
      @(posedge clk);
      txn_valid <= 1'b0;
      ap <= 1'b0;
      #1;
   endtask : ev
   task automatic pulse(input logic [2:0] c, input logic s);
      @(posedge clk);
      {paddr, saddr, tab, mab, tout, as} <= {c == 0 && !s, c == 0 && s, c == 1, c == 2, c == 3, c == 4};
      isec <= s;
      @(posedge clk);
      {paddr, saddr, tab, mab, tout, as} <= 6'h00;
      #1;
   endtask : pulse
   task automatic rp(input int n, input logic [2:0] c);
      repeat (n) begin
         @(posedge clk);
         rpul <= c;
         @(posedge clk);
         rpul <= 3'h0;
      end
   endtask : rp
   always @(posedge clk) begin
      cyc++;
      if (rdisc[0] === 1'b1) ndisc++;
      if (cyc == 5000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      // ctrl, dis, condition, secondary side, expected {primary, secondary} serr
      tbl = '{{6'h0F, 16'h0, 3'h0, 1'b0, 2'b10}, {6'h0E, 16'h0, 3'h0, 1'b0, 2'b00},
         {6'h0F, 16'h0, 3'h0, 1'b1, 2'b01}, {6'h0C, 16'h0, 3'h1, 1'b1, 2'b01},
         {6'h08, 16'h0, 3'h1, 1'b0, 2'b00}, {6'h0C, 16'h0004, 3'h1, 1'b0, 2'b00},
         {6'h0C, 16'h0400, 3'h1, 1'b0, 2'b10}, {6'h0C, 16'h0, 3'h2, 1'b0, 2'b00},
         {6'h2C, 16'h0, 3'h2, 1'b0, 2'b10}, {6'h0C, 16'h0, 3'h3, 1'b0, 2'b10},
         {6'h14, 16'h0, 3'h4, 1'b0, 2'b10}, {6'h04, 16'h0, 3'h4, 1'b0, 2'b00}};
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b1, 4'hC, 32'hFFFF_FFFF);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 4'(i * 4), 32'h0);
         `CHK("reset_rd", 32'h0, q)
      end
      bus(1'b1, 4'h0, 32'hFFFF_FFFF);
      bus(1'b0, 4'h0, 32'h0);
      `CHK("ctrl_rw", 32'h0000_003F, q)
      bus(1'b1, 4'h0, 32'h0000_0002);
      ev(3'h1, 1'b1, 1'b0, 1'b0);
      `CHK("fwd", 1'b1, fwd)
      `CHK("sperr", 2'b10, {sp_oe, sp_out})
      st(32'h2);
      ev(3'h3, 1'b1, 1'b1, 1'b0);
      `CHK("drop", 4'hF, {drop, rtrdy, rstop, sp_oe})
      st(32'h2);
      ev(3'h4, 1'b1, 1'b0, 1'b0);
      `CHK("rd_sperr", 2'b10, {sp_oe, sp_out})
      st(32'h3);
      ev(3'h6, 1'b1, 1'b0, 1'b0);
      `CHK("cfg_sperr", 2'b10, {sp_oe, sp_out})
      st(32'h2);
      ev(3'h7, 1'b1, 1'b0, 1'b0);
      `CHK("cfgrd_oe", 1'b0, sp_oe)
      st(32'h0);
      bus(1'b1, 4'h0, 32'h0000_0000);
      ev(3'h3, 1'b1, 1'b1, 1'b0);
      `CHK("drop_off", 1'b0, drop)
      bus(1'b1, 4'h0, 32'h0000_0007);
      ev(3'h0, 1'b0, 1'b0, 1'b1);
      `CHK("dnpw_pserr", 2'b10, {ps_oe, ps_out})
      st(32'h5);
      bus(1'b1, 4'h0, 32'h0000_0006);
      ev(3'h0, 1'b0, 1'b0, 1'b1);
      `CHK("dnpw_nopserr", 1'b0, ps_oe)
      st(32'h1);
      bus(1'b1, 4'h0, 32'h0000_0003);
      ev(3'h2, 1'b0, 1'b0, 1'b1);
      `CHK("dw_early", 1'b0, pp_oe)
      @(posedge clk);
      trdy <= 1'b1;
      @(posedge clk);
      trdy <= 1'b0;
      #1;
      `CHK("dw_pperr", 2'b10, {pp_oe, pp_out})
      st(32'h1);
      for (int i = 0; i < 12; i++) begin
         bus(1'b1, 4'h0, {26'h0, tbl[i][27:22]});
         bus(1'b1, 4'h4, {16'h0, tbl[i][21:6]});
         pulse(tbl[i][5:3], tbl[i][2]);
         `CHK("serr", {tbl[i][1:0], tbl[i][5:3] == 3'h3}, {ps_oe, ss_oe, cdisc})
      end
      bus(1'b1, 4'h0, 32'h0000_0004);
      bus(1'b1, 4'h4, 32'h0000_0000);
      rp(RL_SIM - 1, 3'h1);
      @(posedge clk);
      rdone <= 3'h1;
      @(posedge clk);
      rdone <= 3'h0;
      rp(RL_SIM - 1, 3'h1);
      repeat (2) @(posedge clk);
      `CHK("no_discard", 0, ndisc)
      rp(1, 3'h1);
      repeat (2) @(posedge clk);
      `CHK("discard", 1, ndisc)
      bus(1'b1, 4'h0, 32'h0000_000C);
      rsec <= 3'h4;
      rp(RL_SIM, 3'h4);
      #1;
      `CHK("rd_disc", 5'h12, {rdisc, ss_oe, ps_oe})
      print_verdict();
   end
endmodule : tb

// ==== verilog/pberr_pkg.sv ====
package pberr_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] DIS_OFS = 4'h4;
   localparam logic [3:0] STAT_OFS = 4'h8;
   localparam int CTRL_W = 6;
   localparam int CTRL_PPER = 0;
   localparam int CTRL_SPER = 1;
   localparam int CTRL_PSERR_EN = 2;
   localparam int CTRL_SSERR_EN = 3;
   localparam int CTRL_FWD_EN = 4;
   localparam int CTRL_MA_MODE = 5;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam int DIS_W = 16;
   localparam int DIS_SEC_POS = 8;
   localparam logic [15:0] DIS_RST = 16'h0000;
   localparam int ST_W = 4;
   localparam int ST_SDPD = 0;
   localparam int ST_SDPE = 1;
   localparam int ST_PSERR = 2;
   localparam int ST_SSERR = 3;
   localparam logic [3:0] ST_RST = 4'h0;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   // ----------------------------------------
   // system error conditions, one disable bit each per interface
   // ----------------------------------------
   localparam int NCOND = 8;
   localparam int C_ADDR = 0;
   localparam int C_TGT_PAR = 1;
   localparam int C_TABORT = 2;
   localparam int C_MABORT = 3;
   localparam int C_RETRY_PW = 4;
   localparam int C_RETRY_DW = 5;
   localparam int C_RETRY_DR = 6;
   localparam int C_TIMEOUT = 7;
   // ----------------------------------------
   // retry limit
   // ----------------------------------------
   localparam int NRETRY = 3;
   localparam int RETRY_LIMIT = 16777216;
   localparam int RETRY_CNT_W = 25;
   // ----------------------------------------
   // transaction kinds on the secondary bus
   // ----------------------------------------
   typedef enum logic [2:0] {
      K_DN_PW,
      K_UP_PW,
      K_DN_DW,
      K_UP_DW,
      K_DN_DR,
      K_UP_DR,
      K_CFG_WR,
      K_CFG_RD
   } pberr_kind_t;
endpackage : pberr_pkg

// ==== verilog/pberr_top.sv ====
// Function
// - downstream posted write: flag on sensed perr
// - target-only perr raises primary serr
// - upstream posted write forwarded, flag set
// - secondary perr driven when response enabled
// - downstream delayed write: primary perr at trdy
// - upstream delayed write dropped, trdy/stop, perr
// - downstream delayed read returns bad parity
// - read also sets flag, drives secondary perr
// - config write stored, detected flag set
// - config write drives secondary perr
// - config read touches no flag
// - separate primary and secondary serr outputs
// - serr gated by interface enable bit
// - per-condition per-interface disable mask
// - address parity serr gated by response
// - target-bus-only parity serr gated
// - target abort, master abort with mode
// - discard after retry limit, raise serr
// - completion discard on timeout raises serr
// - serr on initiator's interface
// - forward secondary serr to primary
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pberr_top #(
   parameter int RETRY_LIMIT = pberr_pkg::RETRY_LIMIT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic txn_valid,
   input wire logic [2:0] txn_kind,
   input wire logic txn_sec_data_perr,
   input wire logic txn_pri_perr_seen,
   input wire logic txn_multi_phase,
   input wire logic pri_trdy_return,
   input wire logic secondary_perr_n_in,
   output logic secondary_perr_n_out,
   output logic secondary_perr_n_oe,
   output logic primary_perr_n_out,
   output logic primary_perr_n_oe,
   input wire logic pri_addr_perr,
   input wire logic sec_addr_perr,
   input wire logic pw_target_abort,
   input wire logic pw_master_abort,
   input wire logic pw_init_sec,
   input wire logic [2:0] retry_pulse,
   input wire logic [2:0] retry_done,
   input wire logic [2:0] retry_init_sec,
   input wire logic cpl_timeout,
   input wire logic cpl_init_sec,
   input wire logic secondary_serr_n_in,
   output logic secondary_serr_n_out,
   output logic secondary_serr_n_oe,
   output logic primary_serr_n_out,
   output logic primary_serr_n_oe,
   output logic fwd_bad_parity,
   output logic drop_write,
   output logic ret_trdy,
   output logic ret_stop,
   output logic [2:0] retry_discard,
   output logic cpl_discard
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic serr_want(
      input logic [pberr_pkg::NCOND-1:0] cond,
      input logic [pberr_pkg::NCOND-1:0] dis,
      input logic en
   );
      serr_want = en & (|(cond & ~dis));
   endfunction : serr_want

   localparam logic [pberr_pkg::RETRY_CNT_W-1:0] RLIM_M1 =
      pberr_pkg::RETRY_CNT_W'(RETRY_LIMIT - 1);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [pberr_pkg::CTRL_W-1:0] ctrl_reg;
   logic [pberr_pkg::CTRL_W-1:0] ctrl_next;
   logic [pberr_pkg::DIS_W-1:0] dis_reg;
   logic [pberr_pkg::DIS_W-1:0] dis_next;
   logic [pberr_pkg::ST_W-1:0] stat_reg;
   logic [pberr_pkg::ST_W-1:0] stat_next;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_mux;
   logic sperr_out_reg;
   logic sperr_oe_reg;
   logic pperr_out_reg;
   logic pperr_oe_reg;
   logic pperr_pend_reg;
   logic sserr_out_reg;
   logic sserr_oe_reg;
   logic pserr_out_reg;
   logic pserr_oe_reg;
   logic fwd_reg;
   logic drop_reg;
   logic trdy_reg;
   logic stop_reg;
   logic [2:0] discard_reg;
   logic cpl_discard_reg;
   logic [pberr_pkg::RETRY_CNT_W-1:0] retry_cnt_reg [pberr_pkg::NRETRY];

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   pberr_pkg::pberr_kind_t kind;
   logic wr_ok;
   logic sel_ctrl;
   logic sel_dis;
   logic sel_stat;
   logic [pberr_pkg::ST_W-1:0] st_clr;
   logic wait_next;

   assign kind = pberr_pkg::pberr_kind_t'(txn_kind);
   assign wr_ok = avs_write & ~wait_reg;
   assign sel_ctrl = avs_address == pberr_pkg::CTRL_OFS;
   assign sel_dis = avs_address == pberr_pkg::DIS_OFS;
   assign sel_stat = avs_address == pberr_pkg::STAT_OFS;
   assign wait_next = ~((avs_read | avs_write) & wait_reg);

   always_comb begin
      if (sel_ctrl) begin
         rd_mux = {26'h0000000, ctrl_reg};
      end else if (sel_dis) begin
         rd_mux = {16'h0000, dis_reg};
      end else if (sel_stat) begin
         rd_mux = {28'h0000000, stat_reg};
      end else begin
         rd_mux = pberr_pkg::RD_UNMAPPED;
      end
   end

   assign ctrl_next = (wr_ok & sel_ctrl & avs_byteenable[0]) ?
      avs_writedata[pberr_pkg::CTRL_W-1:0] : ctrl_reg;
   assign dis_next[7:0] = (wr_ok & sel_dis & avs_byteenable[0]) ?
      avs_writedata[7:0] : dis_reg[7:0];
   assign dis_next[15:8] = (wr_ok & sel_dis & avs_byteenable[1]) ?
      avs_writedata[15:8] : dis_reg[15:8];
   assign st_clr = (wr_ok & sel_stat & avs_byteenable[0]) ?
      avs_writedata[pberr_pkg::ST_W-1:0] : 4'h0;

   // ----------------------------------------
   // secondary data parity decode
   // ----------------------------------------
   logic pper;
   logic sper;
   logic sperr_seen;
   logic sdp;
   logic is_dn_pw;
   logic is_up_pw;
   logic is_dn_dw;
   logic is_up_dw;
   logic is_dn_dr;
   logic is_cfg_wr;
   logic set_sdpd;
   logic set_sdpe;
   logic drive_sperr;
   logic arm_pperr;
   logic pperr_go;
   logic tgt_par_pri;
   logic up_dw_stop;

   assign pper = ctrl_reg[pberr_pkg::CTRL_PPER];
   assign sper = ctrl_reg[pberr_pkg::CTRL_SPER];
   assign sperr_seen = ~secondary_perr_n_in;
   assign sdp = txn_sec_data_perr;
   assign is_dn_pw = txn_valid & (kind == pberr_pkg::K_DN_PW);
   assign is_up_pw = txn_valid & (kind == pberr_pkg::K_UP_PW);
   assign is_dn_dw = txn_valid & (kind == pberr_pkg::K_DN_DW);
   assign is_up_dw = txn_valid & (kind == pberr_pkg::K_UP_DW);
   assign is_dn_dr = txn_valid & (kind == pberr_pkg::K_DN_DR);
   assign is_cfg_wr = txn_valid & (kind == pberr_pkg::K_CFG_WR);
   // upstream delayed reads and config reads need no decode here:
   // initiator acts

   assign set_sdpd = ((is_dn_pw | is_dn_dw) & sper & sperr_seen) |
                     (is_dn_dr & sdp & sper);
   assign set_sdpe = sdp & (is_up_pw | (is_up_dw & sper) | is_dn_dr | is_cfg_wr);
   assign drive_sperr = sdp & sper & (is_up_pw | is_up_dw | is_dn_dr | is_cfg_wr);
   assign arm_pperr = is_dn_dw & pper & sper & sperr_seen;
   assign pperr_go = pperr_pend_reg & pri_trdy_return;
   assign tgt_par_pri = is_dn_pw & pper & sper & sperr_seen & ~txn_pri_perr_seen;
   assign up_dw_stop = is_up_dw & sdp & sper;

   // ----------------------------------------
   // retry counters
   // ----------------------------------------
   logic [2:0] retry_hit;

   genvar g;
   generate
      for (g = 0; g < pberr_pkg::NRETRY; g++) begin : g_retry
         assign retry_hit[g] = retry_pulse[g] & (retry_cnt_reg[g] == RLIM_M1);
         always_ff @(posedge clk) begin
            if (!rst_n || retry_done[g] || retry_hit[g]) begin
               retry_cnt_reg[g] <= '0;
            end else if (retry_pulse[g]) begin
               retry_cnt_reg[g] <= retry_cnt_reg[g] + 1'b1;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // system error conditions
   // ----------------------------------------
   logic [5:0] ev_hi;
   logic [5:0] side_hi;
   logic [pberr_pkg::NCOND-1:0] cond_pri;
   logic [pberr_pkg::NCOND-1:0] cond_sec;
   logic [pberr_pkg::NCOND-1:0] dis_pri;
   logic [pberr_pkg::NCOND-1:0] dis_sec;
   logic raise_pserr;
   logic raise_sserr;
   logic fwd_serr;

   assign ev_hi = {cpl_timeout, retry_hit,
                   pw_master_abort & ctrl_reg[pberr_pkg::CTRL_MA_MODE], pw_target_abort};
   assign side_hi = {cpl_init_sec, retry_init_sec, pw_init_sec, pw_init_sec};
   assign cond_pri = {ev_hi & ~side_hi, tgt_par_pri, pri_addr_perr & pper};
   assign cond_sec = {ev_hi & side_hi, 1'b0, sec_addr_perr & sper};
   assign dis_pri = dis_reg[pberr_pkg::DIS_SEC_POS-1:0];
   assign dis_sec = dis_reg[pberr_pkg::DIS_W-1:pberr_pkg::DIS_SEC_POS];
   assign fwd_serr = ctrl_reg[pberr_pkg::CTRL_FWD_EN] &
                     (~secondary_serr_n_in | sserr_oe_reg);
   assign raise_pserr = serr_want(cond_pri, dis_pri, ctrl_reg[pberr_pkg::CTRL_PSERR_EN]) |
                        (ctrl_reg[pberr_pkg::CTRL_PSERR_EN] & fwd_serr);
   assign raise_sserr = serr_want(cond_sec, dis_sec, ctrl_reg[pberr_pkg::CTRL_SSERR_EN]);

   // status sets win over same-cycle clears
   assign stat_next = (stat_reg & ~st_clr) |
                      {raise_sserr, raise_pserr, set_sdpe, set_sdpd};

   // ----------------------------------------
   // register file and bus answer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_reg <= pberr_pkg::CTRL_RST;
         dis_reg <= pberr_pkg::DIS_RST;
         stat_reg <= pberr_pkg::ST_RST;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         dis_reg <= dis_next;
         stat_reg <= stat_next;
         wait_reg <= wait_next;
         rdata_reg <= wait_reg ? rd_mux : rdata_reg;
      end
   end

   // ----------------------------------------
   // parity error pins
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sperr_out_reg <= 1'b1;
         sperr_oe_reg <= 1'b0;
      end else if (drive_sperr) begin
         sperr_out_reg <= 1'b0;
         sperr_oe_reg <= 1'b1;
      end else begin
         sperr_out_reg <= 1'b1;
         sperr_oe_reg <= sperr_oe_reg & ~sperr_out_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pperr_out_reg <= 1'b1;
         pperr_oe_reg <= 1'b0;
         pperr_pend_reg <= 1'b0;
      end else begin
         pperr_pend_reg <= arm_pperr | (pperr_pend_reg & ~pperr_go);
         pperr_out_reg <= ~pperr_go;
         pperr_oe_reg <= pperr_go | (pperr_oe_reg & ~pperr_out_reg);
      end
   end

   // ----------------------------------------
   // serr pins and actions
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pserr_out_reg <= 1'b1;
         pserr_oe_reg <= 1'b0;
         sserr_out_reg <= 1'b1;
         sserr_oe_reg <= 1'b0;
      end else begin
         pserr_out_reg <= ~raise_pserr;
         pserr_oe_reg <= raise_pserr;
         sserr_out_reg <= ~raise_sserr;
         sserr_oe_reg <= raise_sserr;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fwd_reg <= 1'b0;
         drop_reg <= 1'b0;
         trdy_reg <= 1'b0;
         stop_reg <= 1'b0;
         discard_reg <= 3'h0;
         cpl_discard_reg <= 1'b0;
      end else begin
         fwd_reg <= sdp & (is_up_pw | is_dn_dr);
         drop_reg <= up_dw_stop;
         trdy_reg <= up_dw_stop;
         stop_reg <= up_dw_stop & txn_multi_phase;
         discard_reg <= retry_hit;
         cpl_discard_reg <= cpl_timeout;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign secondary_perr_n_out = sperr_out_reg;
   assign secondary_perr_n_oe = sperr_oe_reg;
   assign primary_perr_n_out = pperr_out_reg;
   assign primary_perr_n_oe = pperr_oe_reg;
   assign secondary_serr_n_out = sserr_out_reg;
   assign secondary_serr_n_oe = sserr_oe_reg;
   assign primary_serr_n_out = pserr_out_reg;
   assign primary_serr_n_oe = pserr_oe_reg;
   assign fwd_bad_parity = fwd_reg;
   assign drop_write = drop_reg;
   assign ret_trdy = trdy_reg;
   assign ret_stop = stop_reg;
   assign retry_discard = discard_reg;
   assign cpl_discard = cpl_discard_reg;
endmodule : pberr_top
